// File: inc/lpcg_cfg.svh
// Constants of the low power clock gating bank: addresses, bit positions and reset values.
`ifndef LPCG_CFG_SVH
`define LPCG_CFG_SVH

// ==========================================================================
// Address map
`define LPCG_BASE_ADDR      32'h400f_e000
`define LPCG_OFS_RUN        32'h0000_0100
`define LPCG_OFS_SLEEP      32'h0000_0110
`define LPCG_OFS_DEEP       32'h0000_0120
`define LPCG_OFS_CONFIG     32'h0000_01f0
`define LPCG_OFS_STATUS     32'h0000_01f4

// ==========================================================================
// Field positions
`define LPCG_BIT_CAU2       26
`define LPCG_BIT_CAU1       25
`define LPCG_BIT_CAU0       24
`define LPCG_BIT_LPM        6
`define LPCG_BIT_WDOG       3
`define LPCG_BIT_AUTO       0
`define LPCG_STAT_MODE_LSB  8
`define LPCG_STAT_MODE_MSB  10

// ==========================================================================
// Reset values and widths
`define LPCG_GATE_RST       32'h0000_0040
`define LPCG_AUTO_RST       1'b0
`define LPCG_UNITS          5

`endif

// File: inc/lpcg_pkg.sv
// Types shared by the low power clock gating bank.
`include "lpcg_cfg.svh"

package lpcg_pkg;

   // =======================================================================
   // One enable per gated unit, in register bit order.
   typedef struct packed
   {
      logic cau2;
      logic cau1;
      logic cau0;
      logic lpm;
      logic wdog;
   } lpcg_gate_t;

   typedef enum logic [2:0]
   {
      LPCG_RUN   = 3'b001,
      LPCG_SLEEP = 3'b010,
      LPCG_DEEP  = 3'b100
   } lpcg_mode_t;

   // =======================================================================
   // Placing and picking the gate bits keeps every other position at zero.
   function automatic logic [31:0] lpcg_to_word(input lpcg_gate_t g);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`LPCG_BIT_CAU2] = g.cau2;
      w[`LPCG_BIT_CAU1] = g.cau1;
      w[`LPCG_BIT_CAU0] = g.cau0;
      w[`LPCG_BIT_LPM]  = g.lpm;
      w[`LPCG_BIT_WDOG] = g.wdog;
      return w;
   endfunction

   function automatic lpcg_gate_t lpcg_from_word(input logic [31:0] w);
      lpcg_gate_t g;
      g.cau2 = w[`LPCG_BIT_CAU2];
      g.cau1 = w[`LPCG_BIT_CAU1];
      g.cau0 = w[`LPCG_BIT_CAU0];
      g.lpm  = w[`LPCG_BIT_LPM];
      g.wdog = w[`LPCG_BIT_WDOG];
      return g;
   endfunction

endpackage

// File: rtl/lpcg_mode_sel.sv
// Power mode tracker and choice of the gating register in force.
`timescale 1ns/1ps
`default_nettype none

module lpcg_mode_sel
(
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   input  wire logic               sleep_mode,
   input  wire logic               deep_sleep_mode,
   input  wire logic               auto_clock_gating,
   input  wire lpcg_pkg::lpcg_gate_t run_gate,
   input  wire lpcg_pkg::lpcg_gate_t sleep_gate,
   input  wire lpcg_pkg::lpcg_gate_t deep_gate,
   output var  lpcg_pkg::lpcg_mode_t mode_ff,
   output var  lpcg_pkg::lpcg_gate_t active_gate
);
   import lpcg_pkg::*;

   lpcg_mode_t nxt_mode;

   // ========================================================================
   // Mode tracking; deep sleep outranks sleep.
   always_comb
   begin
      nxt_mode = mode_ff;
      case (mode_ff)
         LPCG_RUN:
         begin
            if (deep_sleep_mode)
               nxt_mode = LPCG_DEEP;
            else if (sleep_mode)
               nxt_mode = LPCG_SLEEP;
         end
         LPCG_SLEEP:
         begin
            if (deep_sleep_mode)
               nxt_mode = LPCG_DEEP;
            else if (!sleep_mode)
               nxt_mode = LPCG_RUN;
         end
         LPCG_DEEP:
         begin
            if (!deep_sleep_mode)
               nxt_mode = sleep_mode ? LPCG_SLEEP : LPCG_RUN;
         end
         default:
            nxt_mode = LPCG_RUN;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         mode_ff <= LPCG_RUN;
      else
         mode_ff <= nxt_mode;
   end

   // ========================================================================
   // Register selection.
   always_comb
   begin
      active_gate = run_gate;
      if (auto_clock_gating)
      begin
         if (mode_ff == LPCG_SLEEP)
            active_gate = sleep_gate;
         else if (mode_ff == LPCG_DEEP)
            active_gate = deep_gate;
      end
      else
         active_gate = run_gate;
   end

endmodule

`default_nettype wire

// File: rtl/lpcg_top.sv
// Low power clock gating bank: APB register file, mode choice and per-unit gates.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module lpcg_top
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output var  logic [31:0]          prdata,
   output var  logic                 pready,
   output var  logic                 pslverr,
   input  wire logic                 sleep_mode,
   input  wire logic                 deep_sleep_mode,
   input  wire lpcg_pkg::lpcg_gate_t unit_acc_req,
   output var  lpcg_pkg::lpcg_gate_t unit_clk_en,
   output var  lpcg_pkg::lpcg_gate_t unit_acc_ok,
   output var  lpcg_pkg::lpcg_gate_t unit_acc_fault,
   output var  lpcg_pkg::lpcg_mode_t active_mode
);
   import lpcg_pkg::*;

   // ========================================================================
   // Declarations
   lpcg_gate_t  run_clock_gate_0_ff;
   lpcg_gate_t  sleep_clock_gate_0_ff;
   lpcg_gate_t  deep_sleep_clock_gate_0_ff;
   logic        auto_clock_gating_ff;
   lpcg_gate_t  active_gate;
   lpcg_mode_t  mode_ff;
   lpcg_gate_t  wr_gate;
   logic        setup_phase;
   logic        access_done;
   logic        hit_run;
   logic        hit_sleep;
   logic        hit_deep;
   logic        hit_config;
   logic        hit_status;
   logic        hit_any;
   logic [31:0] nxt_prdata;
   logic [31:0] status_word;
   logic [`LPCG_UNITS-1:0] gate_vec;
   logic [`LPCG_UNITS-1:0] req_vec;
   logic [`LPCG_UNITS-1:0] clk_en_vec;
   logic [`LPCG_UNITS-1:0] ok_vec;
   logic [`LPCG_UNITS-1:0] fault_vec;

   // ========================================================================
   // APB phases
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready;

   // ========================================================================
   // Address decode against the full system address.
   always_comb
   begin
      hit_run    = 1'b0;
      hit_sleep  = 1'b0;
      hit_deep   = 1'b0;
      hit_config = 1'b0;
      hit_status = 1'b0;
      if (paddr == (`LPCG_BASE_ADDR + `LPCG_OFS_RUN))
         hit_run = 1'b1;
      else if (paddr == (`LPCG_BASE_ADDR + `LPCG_OFS_SLEEP))
         hit_sleep = 1'b1;
      else if (paddr == (`LPCG_BASE_ADDR + `LPCG_OFS_DEEP))
         hit_deep = 1'b1;
      else if (paddr == (`LPCG_BASE_ADDR + `LPCG_OFS_CONFIG))
         hit_config = 1'b1;
      else if (paddr == (`LPCG_BASE_ADDR + `LPCG_OFS_STATUS))
         hit_status = 1'b1;
   end

   assign hit_any = hit_run | hit_sleep | hit_deep | hit_config | hit_status;

   // Only the gate positions of a written word are kept.
   assign wr_gate = lpcg_from_word(pwdata);

   // ========================================================================
   // Status word: gates in force and the current mode.
   always_comb
   begin
      status_word = lpcg_to_word(active_gate);
      status_word[`LPCG_STAT_MODE_MSB:`LPCG_STAT_MODE_LSB] = mode_ff;
   end

   // ========================================================================
   // Read data mux; unused positions are zero.
   always_comb
   begin
      nxt_prdata = 32'h0000_0000;
      if (hit_run)
         nxt_prdata = lpcg_to_word(run_clock_gate_0_ff);
      else if (hit_sleep)
         nxt_prdata = lpcg_to_word(sleep_clock_gate_0_ff);
      else if (hit_deep)
         nxt_prdata = lpcg_to_word(deep_sleep_clock_gate_0_ff);
      else if (hit_config)
         nxt_prdata[`LPCG_BIT_AUTO] = auto_clock_gating_ff;
      else if (hit_status)
         nxt_prdata = status_word;
   end

   // ========================================================================
   // APB answer: ready in the first access cycle, error on unmapped addresses.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         pready <= 1'b0;
      else if (setup_phase)
         pready <= 1'b1;
      else if (access_done)
         pready <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         pslverr <= 1'b0;
      else if (setup_phase)
         pslverr <= ~hit_any;
      else if (access_done)
         pslverr <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         prdata <= 32'h0000_0000;
      else if (setup_phase && !pwrite)
         prdata <= nxt_prdata;
      else if (access_done)
         prdata <= 32'h0000_0000;
   end

   // ========================================================================
   // Gating registers, written at the completing edge of the access.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         run_clock_gate_0_ff <= lpcg_from_word(`LPCG_GATE_RST);
      else if (access_done && pwrite && hit_run)
         run_clock_gate_0_ff <= wr_gate;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         sleep_clock_gate_0_ff <= lpcg_from_word(`LPCG_GATE_RST);
      else if (access_done && pwrite && hit_sleep)
         sleep_clock_gate_0_ff <= wr_gate;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         deep_sleep_clock_gate_0_ff <= lpcg_from_word(`LPCG_GATE_RST);
      else if (access_done && pwrite && hit_deep)
         deep_sleep_clock_gate_0_ff <= wr_gate;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         auto_clock_gating_ff <= `LPCG_AUTO_RST;
      else if (access_done && pwrite && hit_config)
         auto_clock_gating_ff <= pwdata[`LPCG_BIT_AUTO];
   end

   // ========================================================================
   // Mode tracking and choice of the register in force.
   lpcg_mode_sel u_mode_sel
   (
      .clk_sys           (clk_sys),
      .rst_b             (rst_b),
      .sleep_mode        (sleep_mode),
      .deep_sleep_mode   (deep_sleep_mode),
      .auto_clock_gating (auto_clock_gating_ff),
      .run_gate          (run_clock_gate_0_ff),
      .sleep_gate        (sleep_clock_gate_0_ff),
      .deep_gate         (deep_sleep_clock_gate_0_ff),
      .mode_ff           (mode_ff),
      .active_gate       (active_gate)
   );

   assign active_mode = mode_ff;

   // ========================================================================
   // Per-unit gates; vector order is cau2, cau1, cau0, lpm, wdog from the top.
   assign gate_vec = active_gate;
   assign req_vec  = unit_acc_req;

   genvar gi;
   generate
      for (gi = 0; gi < `LPCG_UNITS; gi = gi + 1)
      begin : g_unit
         lpcg_unit_gate u_gate
         (
            .clk_sys      (clk_sys),
            .rst_b        (rst_b),
            .gate_on      (gate_vec[gi]),
            .acc_req      (req_vec[gi]),
            .clk_en_ff    (clk_en_vec[gi]),
            .acc_ok_ff    (ok_vec[gi]),
            .acc_fault_ff (fault_vec[gi])
         );
      end
   endgenerate

   assign unit_clk_en    = clk_en_vec;
   assign unit_acc_ok    = ok_vec;
   assign unit_acc_fault = fault_vec;

endmodule

`default_nettype wire

// File: rtl/lpcg_unit_gate.sv
// Clock enable and bus access guard for one gated unit.
`timescale 1ns/1ps
`default_nettype none

module lpcg_unit_gate
(
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic gate_on,
   input  wire logic acc_req,
   output var  logic clk_en_ff,
   output var  logic acc_ok_ff,
   output var  logic acc_fault_ff
);

   // ========================================================================
   // Clock enable follows the gating bit in force.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         clk_en_ff <= 1'b0;
      else
         clk_en_ff <= gate_on;
   end

   // ========================================================================
   // An access is judged against the enable the unit actually has now.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         acc_ok_ff    <= 1'b0;
         acc_fault_ff <= 1'b0;
      end
      else
      begin
         acc_ok_ff    <= acc_req & clk_en_ff;
         acc_fault_ff <= acc_req & ~clk_en_ff;
      end
   end

endmodule

`default_nettype wire

// File: tb/lpcg_checker.sv
// Port-level checks of the low power clock gating bank.
`timescale 1ns/1ps
`default_nettype none
`include "lpcg_cfg.svh"

module lpcg_checker
(
   input wire logic                 clk_sys,
   input wire logic                 rst_b,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          paddr,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 sleep_mode,
   input wire logic                 deep_sleep_mode,
   input wire lpcg_pkg::lpcg_gate_t unit_acc_req,
   input wire lpcg_pkg::lpcg_gate_t unit_clk_en,
   input wire lpcg_pkg::lpcg_gate_t unit_acc_ok,
   input wire lpcg_pkg::lpcg_gate_t unit_acc_fault,
   input wire lpcg_pkg::lpcg_mode_t active_mode
);
   import lpcg_pkg::*;
   localparam logic [31:0] B = `LPCG_BASE_ADDR;
   logic gate_hit;
   logic map_hit;
   logic setup;
   assign gate_hit = paddr inside {B + 32'h100, B + 32'h110, B + 32'h120};
   assign map_hit = gate_hit || paddr inside {B + 32'h1f0, B + 32'h1f4};
   assign setup = psel && !penable;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // ======================================================================
   // Assertions
   a_fault_when_off: assert property (1 |=> unit_acc_fault == ($past(unit_acc_req) & ~$past(unit_clk_en)))
      else $error("unit fault does not follow a request to an unclocked unit");
   a_ok_when_on: assert property (1 |=> unit_acc_ok == ($past(unit_acc_req) & $past(unit_clk_en)))
      else $error("unit completion does not follow a request to a clocked unit");
   a_wdog_fault: assert property (unit_acc_req.wdog && !unit_clk_en.wdog |=> unit_acc_fault.wdog)
      else $error("watchdog access while unclocked gave no fault");
   a_reserved_zero: assert property (pready && !pwrite && gate_hit |-> (prdata & ~32'h0700_0048) == 32'h0)
      else $error("reserved gating bits read nonzero");
   a_run_mode: assert property (!sleep_mode && !deep_sleep_mode |=> active_mode == LPCG_RUN)
      else $error("run mode not in force");
   a_sleep_mode: assert property (sleep_mode && !deep_sleep_mode |=> active_mode == LPCG_SLEEP)
      else $error("sleep mode not in force");
   a_deep_mode: assert property (deep_sleep_mode |=> active_mode == LPCG_DEEP)
      else $error("deep sleep mode not in force");
   a_unmapped_err: assert property (setup && !map_hit |=> pready && pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (setup && map_hit |=> pready && !pslverr)
      else $error("mapped access not completed cleanly");
   a_ready_once: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   c_fault: cover property (unit_acc_fault != 5'h0);
   c_ok: cover property (unit_acc_ok != 5'h0);
   c_err: cover property (pslverr);
   c_deep: cover property (active_mode == LPCG_DEEP);
endmodule

bind lpcg_top lpcg_checker chk_u
(
   .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sleep_mode,
   .deep_sleep_mode, .unit_acc_req, .unit_clk_en, .unit_acc_ok, .unit_acc_fault, .active_mode
);
`default_nettype wire

// File: tb/lpcg_top_tb.sv
// Self-checking bench of the low power clock gating bank.
`timescale 1ns/1ps
`default_nettype none
`include "lpcg_cfg.svh"
`define CHK(nm, ex, got) \
   begin \
      n_checks++; \
      if ((got) !== (ex)) \
      begin \
         n_fail++; \
         $display("mismatch %s expected %h seen %h", nm, ex, got); \
      end \
   end

module lpcg_top_tb;
   import lpcg_pkg::*;
   logic        clk_sys;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sleep_mode;
   logic        deep_sleep_mode;
   lpcg_gate_t  unit_acc_req;
   lpcg_gate_t  unit_clk_en;
   lpcg_gate_t  unit_acc_ok;
   lpcg_gate_t  unit_acc_fault;
   lpcg_mode_t  active_mode;
   logic [31:0] r_q;
   logic        e_q;
   int          n_fail;
   int          n_checks;
   localparam int POS [5] = '{3, 6, 24, 25, 26};
   localparam logic [31:0] GOFS [3] = '{32'h100, 32'h110, 32'h120};

   lpcg_top dut_u
   (
      .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_mode,
      .deep_sleep_mode, .unit_acc_req, .unit_clk_en, .unit_acc_ok, .unit_acc_fault, .active_mode
   );

   // ======================================================================
   // Bus and unit access tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic apb(input logic w, input logic [31:0] ofs, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= `LPCG_BASE_ADDR + ofs;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (pready !== 1'b1);
      `CHK("wait_cycles", 1, k)
      r_q = prdata;
      e_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [31:0] ofs, input logic [31:0] ex, input logic err);
      apb(1'b0, ofs, 32'h0);
      `CHK("prdata", ex, r_q)
      `CHK("pslverr", err, e_q)
   endtask

   task automatic pulse();
      unit_acc_req <= 5'h1f;
      @(posedge clk_sys);
      unit_acc_req <= 5'h00;
      @(posedge clk_sys);
   endtask

   task automatic finish_test();
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ======================================================================
   // Clock, watchdog and test sequence
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial
   begin
      #40000;
      n_fail++;
      finish_test();
   end

   initial
   begin
      {rst_b, psel, penable, pwrite, sleep_mode, deep_sleep_mode} = 6'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      unit_acc_req = 5'h00;
      n_fail = 0;
      n_checks = 0;
      tick(12);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      foreach (GOFS[i]) rd(GOFS[i], 32'h0000_0040, 1'b0);
      rd(32'h1f0, 32'h0, 1'b0);
      `CHK("clk_en", 5'b00010, unit_clk_en)
      foreach (GOFS[i])
      begin
         apb(1'b1, GOFS[i], 32'hffff_ffff);
         rd(GOFS[i], 32'h0700_0048, 1'b0);
      end
      rd(32'h1f4, 32'h0700_0148, 1'b0);
      rd(32'h104, 32'h0, 1'b1);
      rd(32'h000, 32'h0, 1'b1);
      for (int j = 0; j < 5; j++)
      begin
         apb(1'b1, 32'h100, 32'h1 << POS[j]);
         tick(1);
         `CHK("clk_en", 5'(1 << j), unit_clk_en)
         pulse();
         `CHK("acc_ok", 5'(1 << j), unit_acc_ok)
         `CHK("acc_fault", ~5'(1 << j), unit_acc_fault)
      end
      apb(1'b1, 32'h110, 32'h0100_0000);
      apb(1'b1, 32'h120, 32'h0000_0040);
      apb(1'b0, 32'h100, 32'h0);
      apb(1'b1, 32'h100, (r_q & ~32'h0400_0000) | 32'h8);
      sleep_mode <= 1'b1;
      tick(3);
      `CHK("mode", LPCG_SLEEP, active_mode)
      `CHK("clk_en", 5'b00001, unit_clk_en)
      apb(1'b1, 32'h1f0, 32'h1);
      tick(1);
      `CHK("clk_en", 5'b00100, unit_clk_en)
      deep_sleep_mode <= 1'b1;
      tick(3);
      `CHK("mode", LPCG_DEEP, active_mode)
      `CHK("clk_en", 5'b00010, unit_clk_en)
      pulse();
      `CHK("acc_fault", 5'b11101, unit_acc_fault)
      sleep_mode <= 1'b0;
      deep_sleep_mode <= 1'b0;
      tick(3);
      `CHK("mode", LPCG_RUN, active_mode)
      `CHK("clk_en", 5'b00001, unit_clk_en)
      rst_b <= 1'b0;
      tick(3);
      rst_b <= 1'b1;
      tick(1);
      rd(32'h110, 32'h0000_0040, 1'b0);
      rd(32'h1f0, 32'h0, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
